// [include/aecr_pkg.sv]
// Purpose: constants for the correctable-error register bank of one switch port
// Assumes: 32-bit AHB-Lite register bus, one core clock
// Notes: byte offsets are the printed offsets
package aecr_pkg;
   localparam logic [11:0] AECR_OFS_STATUS = 12'h110;
   localparam logic [11:0] AECR_OFS_MASK = 12'h114;
   localparam logic [11:0] AECR_OFS_CTRL = 12'h118;
   localparam logic [11:0] AECR_OFS_IRQ_STAT = 12'h140;
   localparam logic [11:0] AECR_OFS_IRQ_CLR = 12'h144;
   localparam logic [11:0] AECR_OFS_IRQ_EN = 12'h148;

   localparam int AECR_BIT_RCV = 0;
   localparam int AECR_BIT_BADPKT = 6;
   localparam int AECR_BIT_BADLNK = 7;
   localparam int AECR_BIT_ROLL = 8;
   localparam int AECR_BIT_RTO = 12;
   localparam int AECR_BIT_ADV = 13;
   localparam int AECR_NUM_EVT = 6;

   // implemented bits of status, mask and interrupt registers
   localparam logic [31:0] AECR_EVT_BITS = 32'h000031C1;
   localparam logic [31:0] AECR_STATUS_RST = 32'h00000000;
   localparam logic [31:0] AECR_MASK_RST = 32'h00002000;

   localparam int AECR_FEP_LSB = 0;
   localparam int AECR_FEP_W = 5;
   localparam int AECR_CTL_GCAP = 5;
   localparam int AECR_CTL_GEN = 6;
   localparam int AECR_CTL_CCAP = 7;
   localparam int AECR_CTL_CEN = 8;
   localparam logic AECR_CAP_RST = 1'b1;
   localparam logic AECR_EN_RST = 1'b0;
   localparam logic [4:0] AECR_FEP_RST = 5'h00;

   localparam logic [1:0] AECR_HTRANS_NONSEQ = 2'h2;
   localparam logic AECR_HRESP_OKAY = 1'b0;
   localparam logic [31:0] AECR_ZERO = 32'h00000000;
endpackage : aecr_pkg

// [logic/aecr_regs.sv]
// Purpose: correctable-error status, mask and control registers of one port
// Assumes: event inputs are one-cycle pulses from core-clock logic
// Notes: resetn is the fundamental reset, link_resetn the hot or link reset
`timescale 1ns/1ps
`default_nettype none
module aecr_regs (
   input wire logic clk,
   input wire logic resetn,
   input wire logic link_resetn,
   input wire logic hsel,
   input wire logic [11:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic [31:0] hrdata,
   output logic hreadyout,
   output logic hresp,
   input wire logic rx_err_evt,
   input wire logic bad_pkt_evt,
   input wire logic bad_link_pkt_evt,
   input wire logic replay_rollover_evt,
   input wire logic replay_timeout_evt,
   input wire logic advisory_nf_evt,
   input wire logic first_err_load,
   input wire logic [aecr_pkg::AECR_FEP_W-1:0] first_err_ptr_in,
   input wire logic write_lock,
   output logic cor_msg_req,
   output logic crc_gen_capable,
   output logic crc_gen_enable,
   output logic crc_check_capable,
   output logic crc_check_enable,
   output logic irq
);
   import aecr_pkg::*;

   logic [31:0] correctable_error_status_r;
   logic [31:0] correctable_error_mask_r;
   logic [AECR_FEP_W-1:0] first_error_pointer_r;
   logic crc_gen_capable_r;
   logic crc_gen_enable_r;
   logic crc_check_capable_r;
   logic crc_check_enable_r;
   logic [31:0] irq_status_r;
   logic [31:0] irq_enable_r;
   logic cor_msg_req_r;
   logic irq_r;
   logic [31:0] hrdata_r;
   logic hreadyout_r;
   logic hresp_r;

   logic wr_pend_r;
   logic [11:0] wr_addr_r;
   logic [31:0] evt_vec;
   logic [31:0] wr_data;
   logic wr_status;
   logic wr_mask;
   logic wr_ctrl;
   logic wr_irq_clr;
   logic wr_irq_en;
   logic addr_phase;
   logic [31:0] status_nxt;
   logic [31:0] irq_status_nxt;
   logic [31:0] rd_nxt;

   // spread the six event pulses onto their register positions
   function automatic logic [31:0] evt_place(input logic [AECR_NUM_EVT-1:0] e);
      logic [31:0] v;
      v = AECR_ZERO;
      v[AECR_BIT_RCV] = e[0];
      v[AECR_BIT_BADPKT] = e[1];
      v[AECR_BIT_BADLNK] = e[2];
      v[AECR_BIT_ROLL] = e[3];
      v[AECR_BIT_RTO] = e[4];
      v[AECR_BIT_ADV] = e[5];
      return v;
   endfunction : evt_place

   function automatic logic hit(input logic [11:0] a, input logic [11:0] ofs);
      return a == ofs;
   endfunction : hit

   assign evt_vec = evt_place({advisory_nf_evt, replay_timeout_evt, replay_rollover_evt,
                               bad_link_pkt_evt, bad_pkt_evt, rx_err_evt});

   assign addr_phase = hsel && (htrans == AECR_HTRANS_NONSEQ) && hready;
   assign wr_data = hwdata;
   assign wr_status = wr_pend_r && hit(wr_addr_r, AECR_OFS_STATUS);
   assign wr_mask = wr_pend_r && hit(wr_addr_r, AECR_OFS_MASK);
   assign wr_ctrl = wr_pend_r && hit(wr_addr_r, AECR_OFS_CTRL);
   assign wr_irq_clr = wr_pend_r && hit(wr_addr_r, AECR_OFS_IRQ_CLR);
   assign wr_irq_en = wr_pend_r && hit(wr_addr_r, AECR_OFS_IRQ_EN);

   // bus address phase capture; zero wait states so a write lands next cycle
   always_ff @(posedge clk) begin
      if (!resetn || !link_resetn) begin
         wr_pend_r <= 1'b0;
         wr_addr_r <= 12'h000;
      end else begin
         wr_pend_r <= addr_phase && hwrite;
         wr_addr_r <= haddr;
      end
   end

   always_ff @(posedge clk) begin
      if (!resetn || !link_resetn) begin
         hreadyout_r <= 1'b0;
      end else begin
         hreadyout_r <= 1'b1;
      end
   end

   a_ready_up: assert property (@(posedge clk)
      resetn && link_resetn
      |=> hreadyout)
      else $error("bus not ready after reset");

   // okay is the only answer, yet it leaves from a flop like every bus output
   always_ff @(posedge clk) begin
      if (!resetn || !link_resetn) begin
         hresp_r <= AECR_HRESP_OKAY;
      end else begin
         hresp_r <= AECR_HRESP_OKAY;
      end
   end

   // event set wins over a write-one clear in the same cycle
   always_comb begin
      status_nxt = correctable_error_status_r;
      if (wr_status) begin
         status_nxt = status_nxt & ~(wr_data & AECR_EVT_BITS);
      end
      status_nxt = status_nxt | evt_vec;
   end

   // sticky: only the fundamental reset clears it
   always_ff @(posedge clk) begin
      if (!resetn) begin
         correctable_error_status_r <= AECR_STATUS_RST;
      end else begin
         correctable_error_status_r <= status_nxt & AECR_EVT_BITS;
      end
   end

   a_status_reset: assert property (@(posedge clk)
      !resetn
      |=> correctable_error_status_r == AECR_STATUS_RST)
      else $error("status reset value wrong");
   a_w1c_clears: assert property (@(posedge clk) disable iff (!resetn)
      wr_status && hwdata[AECR_BIT_RCV] && !rx_err_evt
      |=> !correctable_error_status_r[AECR_BIT_RCV])
      else $error("write of one did not clear status");
   a_w0_keeps: assert property (@(posedge clk) disable iff (!resetn)
      wr_status && !hwdata[AECR_BIT_RTO] && correctable_error_status_r[AECR_BIT_RTO]
      |=> correctable_error_status_r[AECR_BIT_RTO])
      else $error("write of zero changed status");
   a_status_link: assert property (@(posedge clk) disable iff (!resetn)
      !link_resetn && !wr_status && evt_vec == AECR_ZERO
      |=> $stable(correctable_error_status_r))
      else $error("status changed across link reset");

   always_ff @(posedge clk) begin
      if (!resetn) begin
         correctable_error_mask_r <= AECR_MASK_RST;
      end else if (wr_mask) begin
         correctable_error_mask_r <= wr_data & AECR_EVT_BITS;
      end
   end

   a_mask_write: assert property (@(posedge clk) disable iff (!resetn)
      wr_mask
      |=> correctable_error_mask_r == ($past(hwdata) & AECR_EVT_BITS))
      else $error("mask write not taken");
   a_mask_sticky: assert property (@(posedge clk) disable iff (!resetn)
      !link_resetn && !wr_mask
      |=> $stable(correctable_error_mask_r))
      else $error("mask changed across link reset");

   always_ff @(posedge clk) begin
      if (!resetn) begin
         first_error_pointer_r <= AECR_FEP_RST;
      end else if (first_err_load) begin
         first_error_pointer_r <= first_err_ptr_in;
      end
   end

   a_fep_load: assert property (@(posedge clk) disable iff (!resetn)
      first_err_load
      |=> first_error_pointer_r == $past(first_err_ptr_in))
      else $error("first error pointer not loaded");
   a_fep_hold: assert property (@(posedge clk) disable iff (!resetn)
      !first_err_load
      |=> $stable(first_error_pointer_r))
      else $error("first error pointer changed without load");

   // enables are sticky, capability bits are not
   always_ff @(posedge clk) begin
      if (!resetn) begin
         crc_gen_enable_r <= AECR_EN_RST;
         crc_check_enable_r <= AECR_EN_RST;
      end else if (wr_ctrl) begin
         crc_gen_enable_r <= wr_data[AECR_CTL_GEN];
         crc_check_enable_r <= wr_data[AECR_CTL_CEN];
      end
   end

   a_gen_write: assert property (@(posedge clk) disable iff (!resetn)
      wr_ctrl
      |=> crc_gen_enable == $past(hwdata[AECR_CTL_GEN]))
      else $error("generation enable write not taken");
   a_chk_write: assert property (@(posedge clk) disable iff (!resetn)
      wr_ctrl
      |=> crc_check_enable == $past(hwdata[AECR_CTL_CEN]))
      else $error("checking enable write not taken");

   always_ff @(posedge clk) begin
      if (!resetn || !link_resetn) begin
         crc_gen_capable_r <= AECR_CAP_RST;
         crc_check_capable_r <= AECR_CAP_RST;
      end else if (wr_ctrl && !write_lock) begin
         crc_gen_capable_r <= wr_data[AECR_CTL_GCAP];
         crc_check_capable_r <= wr_data[AECR_CTL_CCAP];
      end
   end

   a_gcap_open: assert property (@(posedge clk) disable iff (!resetn || !link_resetn)
      wr_ctrl && !write_lock
      |=> crc_gen_capable == $past(hwdata[AECR_CTL_GCAP]))
      else $error("generation capable write not taken");
   a_ccap_open: assert property (@(posedge clk) disable iff (!resetn || !link_resetn)
      wr_ctrl && !write_lock
      |=> crc_check_capable == $past(hwdata[AECR_CTL_CCAP]))
      else $error("checking capable write not taken");
   a_cap_reset: assert property (@(posedge clk)
      !resetn || !link_resetn
      |=> crc_gen_capable && crc_check_capable)
      else $error("capable bits not set by reset");

   // one message request per cycle that has any unmasked event
   always_ff @(posedge clk) begin
      if (!resetn || !link_resetn) begin
         cor_msg_req_r <= 1'b0;
      end else begin
         cor_msg_req_r <= |(evt_vec & ~correctable_error_mask_r);
      end
   end

   a_msg_sent: assert property (@(posedge clk) disable iff (!resetn || !link_resetn)
      (evt_vec & ~correctable_error_mask_r) != AECR_ZERO
      |=> cor_msg_req)
      else $error("event not reported to root");
   a_msg_quiet: assert property (@(posedge clk) disable iff (!resetn || !link_resetn)
      (evt_vec & ~correctable_error_mask_r) == AECR_ZERO
      |=> !cor_msg_req)
      else $error("report without an unmasked event");

   // interrupt status: every event, masked or not, set wins over clear
   always_comb begin
      irq_status_nxt = irq_status_r;
      if (wr_irq_clr) begin
         irq_status_nxt = irq_status_nxt & ~wr_data;
      end
      irq_status_nxt = (irq_status_nxt | evt_vec) & AECR_EVT_BITS;
   end

   always_ff @(posedge clk) begin
      if (!resetn || !link_resetn) begin
         irq_status_r <= AECR_ZERO;
      end else begin
         irq_status_r <= irq_status_nxt;
      end
   end

   always_ff @(posedge clk) begin
      if (!resetn || !link_resetn) begin
         irq_enable_r <= AECR_ZERO;
      end else if (wr_irq_en) begin
         irq_enable_r <= wr_data & AECR_EVT_BITS;
      end
   end

   always_ff @(posedge clk) begin
      if (!resetn || !link_resetn) begin
         irq_r <= 1'b0;
      end else begin
         irq_r <= |(irq_status_nxt & irq_enable_r);
      end
   end

   a_irq_set: assert property (@(posedge clk) disable iff (!resetn || !link_resetn)
      (evt_vec & irq_enable_r) != AECR_ZERO
      |=> irq)
      else $error("enabled event raised no interrupt");
   a_irq_quiet: assert property (@(posedge clk) disable iff (!resetn || !link_resetn)
      irq_enable_r == AECR_ZERO
      |=> !irq)
      else $error("interrupt with nothing enabled");

   // read mux; reserved bits and unmapped addresses read zero
   always_comb begin
      rd_nxt = AECR_ZERO;
      case (haddr)
         AECR_OFS_STATUS: rd_nxt = correctable_error_status_r;
         AECR_OFS_MASK: rd_nxt = correctable_error_mask_r;
         AECR_OFS_CTRL: begin
            rd_nxt[AECR_FEP_LSB +: AECR_FEP_W] = first_error_pointer_r;
            rd_nxt[AECR_CTL_GCAP] = crc_gen_capable_r;
            rd_nxt[AECR_CTL_GEN] = crc_gen_enable_r;
            rd_nxt[AECR_CTL_CCAP] = crc_check_capable_r;
            rd_nxt[AECR_CTL_CEN] = crc_check_enable_r;
         end
         AECR_OFS_IRQ_STAT: rd_nxt = irq_status_r;
         AECR_OFS_IRQ_EN: rd_nxt = irq_enable_r;
         default: rd_nxt = AECR_ZERO;
      endcase
   end

   // read data sampled at the address phase, standing through the data phase
   always_ff @(posedge clk) begin
      if (!resetn || !link_resetn) begin
         hrdata_r <= AECR_ZERO;
      end else if (addr_phase && !hwrite) begin
         hrdata_r <= rd_nxt;
      end
   end

   a_rdata_reset: assert property (@(posedge clk)
      !resetn || !link_resetn
      |=> hrdata == AECR_ZERO)
      else $error("read data not cleared by reset");

   assign hrdata = hrdata_r;
   assign hreadyout = hreadyout_r;
   assign hresp = hresp_r;
   assign cor_msg_req = cor_msg_req_r;
   assign crc_gen_capable = crc_gen_capable_r;
   assign crc_gen_enable = crc_gen_enable_r;
   assign crc_check_capable = crc_check_capable_r;
   assign crc_check_enable = crc_check_enable_r;
   assign irq = irq_r;

   a_rcv_sets: assert property (@(posedge clk) disable iff (!resetn)
      rx_err_evt |=> correctable_error_status_r[AECR_BIT_RCV])
      else $error("receiver error did not set status");
   a_badpkt_sets: assert property (@(posedge clk) disable iff (!resetn)
      bad_pkt_evt |=> correctable_error_status_r[AECR_BIT_BADPKT])
      else $error("bad packet did not set status");
   a_badlnk_sets: assert property (@(posedge clk) disable iff (!resetn)
      bad_link_pkt_evt |=> correctable_error_status_r[AECR_BIT_BADLNK])
      else $error("bad link packet did not set status");
   a_roll_sets: assert property (@(posedge clk) disable iff (!resetn)
      replay_rollover_evt |=> correctable_error_status_r[AECR_BIT_ROLL])
      else $error("replay rollover did not set status");
   a_rto_sets: assert property (@(posedge clk) disable iff (!resetn)
      replay_timeout_evt |=> correctable_error_status_r[AECR_BIT_RTO])
      else $error("replay timeout did not set status");
   a_adv_masked_sets: assert property (@(posedge clk) disable iff (!resetn)
      advisory_nf_evt && correctable_error_mask_r[AECR_BIT_ADV]
      |=> correctable_error_status_r[AECR_BIT_ADV] && !cor_msg_req)
      else $error("masked advisory event lost or reported");
   a_status_sticky: assert property (@(posedge clk) disable iff (!resetn)
      $fell(correctable_error_status_r[AECR_BIT_RTO]) && $past(resetn) |->
      $past(wr_status) && $past(hwdata[AECR_BIT_RTO]))
      else $error("status bit fell without a write of one");
   a_mask_report: assert property (@(posedge clk) disable iff (!resetn || !link_resetn)
      rx_err_evt && !correctable_error_mask_r[AECR_BIT_RCV] ##1 link_resetn |-> cor_msg_req)
      else $error("unmasked event not reported");
   a_mask_reset: assert property (@(posedge clk)
      !resetn |=> correctable_error_mask_r == AECR_MASK_RST)
      else $error("mask reset value wrong");
   a_cap_locked: assert property (@(posedge clk) disable iff (!resetn || !link_resetn)
      wr_ctrl && write_lock |=> $stable(crc_gen_capable) && $stable(crc_check_capable))
      else $error("capability bit changed under lock");
   a_sticky_link: assert property (@(posedge clk) disable iff (!resetn)
      !link_resetn && !wr_ctrl |=> $stable(crc_gen_enable) && $stable(crc_check_enable))
      else $error("sticky enable lost on link reset");
endmodule : aecr_regs
`default_nettype wire

// [tb/aecr_root_model.sv]
// Purpose: root complex side: AHB-Lite master and error message counter
// Assumes: one slave, hreadyout is hready, OKAY only
// Notes: xfer is called by the bench right after a rising edge
`timescale 1ns/1ps
`default_nettype none
module aecr_root_model (
   input wire logic clk,
   output logic hsel,
   output logic [11:0] haddr,
   output logic [1:0] htrans,
   output logic hwrite,
   output logic [2:0] hsize,
   output logic [31:0] hwdata,
   input wire logic [31:0] hrdata,
   input wire logic hreadyout,
   input wire logic cor_msg_req
);
   import aecr_pkg::*;
   int msg_count = 0;

   initial begin
      hsel = 1'b0;
      haddr = 12'h000;
      htrans = 2'h0;
      hwrite = 1'b0;
      hsize = 3'h2;
      hwdata = 32'h00000000;
   end

   always @(posedge clk) begin
      if (cor_msg_req === 1'b1) begin
         msg_count <= msg_count + 1;
      end
   end

   task automatic xfer(input logic wr, input logic [11:0] a, input logic [31:0] wd,
                       output logic [31:0] rd);
      hsel <= 1'b1;
      haddr <= a;
      htrans <= AECR_HTRANS_NONSEQ;
      hwrite <= wr;
      do @(posedge clk); while (hreadyout !== 1'b1);
      hsel <= 1'b0;
      htrans <= 2'h0;
      // reads get a changing pattern so stale data is never mistaken
      hwdata <= wr ? wd : ~hwdata;
      do @(posedge clk); while (hreadyout !== 1'b1);
      rd = hrdata;
   endtask : xfer
endmodule : aecr_root_model
`default_nettype wire

// [tb/tb_top.sv]
// Purpose: self-checking bench for the correctable-error register bank
// Assumes: zero-wait slave, events are one-cycle pulses
// Notes: the root model performs the bus cycles and counts messages
`timescale 1ns/1ps
`default_nettype none
module tb_top;
   import aecr_pkg::*;
   logic clk, resetn, link_resetn, hsel, hwrite, hreadyout, hresp, cor_msg_req, irq;
   logic gcap, gen, ccap, cen, first_err_load, write_lock;
   logic [11:0] haddr;
   logic [1:0] htrans;
   logic [2:0] hsize;
   logic [31:0] hwdata, hrdata, exp;
   logic [4:0] ptr;
   logic [13:0] ev;
   int err_count = 0;
   int n_checks = 0;
   int cyc = 0;
   int msgs;
   int pos[6] = '{0, 6, 7, 8, 12, 13};

   initial begin
      clk = 1'b0;
      forever #2.5 clk = ~clk;
   end

   aecr_regs i_dut (.clk(clk), .resetn(resetn), .link_resetn(link_resetn), .hsel(hsel),
      .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
      .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
      .rx_err_evt(ev[0]), .bad_pkt_evt(ev[6]), .bad_link_pkt_evt(ev[7]),
      .replay_rollover_evt(ev[8]), .replay_timeout_evt(ev[12]), .advisory_nf_evt(ev[13]),
      .first_err_load(first_err_load), .first_err_ptr_in(ptr), .write_lock(write_lock),
      .cor_msg_req(cor_msg_req), .crc_gen_capable(gcap), .crc_gen_enable(gen),
      .crc_check_capable(ccap), .crc_check_enable(cen), .irq(irq));

   aecr_root_model i_root (.clk(clk), .hsel(hsel), .haddr(haddr), .htrans(htrans),
      .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hrdata(hrdata),
      .hreadyout(hreadyout), .cor_msg_req(cor_msg_req));

   task automatic chk(input logic [31:0] got, input logic [31:0] want);
      n_checks++;
      if (got !== want) begin
         err_count++;
         $display("[ERR] t=%0t got=%h exp=%h", $time, got, want);
      end
   endtask : chk

   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      logic [31:0] unused;
      i_root.xfer(1'b1, a, d, unused);
   endtask : wr

   task automatic rd_chk(input logic [11:0] a, input logic [31:0] want);
      logic [31:0] got;
      i_root.xfer(1'b0, a, 32'h00000000, got);
      chk(got, want);
   endtask : rd_chk

   task automatic pulse(input int p);
      ev <= 14'h0001 << p;
      @(posedge clk);
      ev <= 14'h0000;
      // quiet cycle so back-to-back pulses never drive ev twice in one step
      @(posedge clk);
   endtask : pulse

   task automatic do_reset(input logic fund);
      resetn <= !fund;
      link_resetn <= fund;
      repeat (2) @(posedge clk);
      resetn <= 1'b1;
      link_resetn <= 1'b1;
      repeat (3) @(posedge clk);
   endtask : do_reset

   task automatic print_verdict;
      $display("checks=%0d mismatches=%0d", n_checks, err_count);
      if (err_count == 0 && n_checks > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask : print_verdict

   // whole run is about 120 cycles
   always @(posedge clk) begin
      cyc++;
      if (cyc == 5000) begin
         err_count++;
         print_verdict();
      end
   end

   initial begin
      resetn = 1'b0;
      link_resetn = 1'b0;
      ev = 14'h0000;
      first_err_load = 1'b0;
      ptr = 5'h00;
      write_lock = 1'b1;
      do_reset(1'b1);
      rd_chk(AECR_OFS_STATUS, 32'h00000000);
      rd_chk(AECR_OFS_MASK, 32'h00002000);
      rd_chk(AECR_OFS_CTRL, 32'h000000A0);
      rd_chk(12'h100, 32'h00000000);
      $display("test defaults done");
      exp = 32'h00000000;
      msgs = i_root.msg_count;
      foreach (pos[i]) begin
         pulse(pos[i]);
         exp = exp | (32'h00000001 << pos[i]);
         rd_chk(AECR_OFS_STATUS, exp);
      end
      // advisory event is masked by default, so one message short
      chk(i_root.msg_count - msgs, 32'h00000005);
      wr(AECR_OFS_STATUS, 32'h00000000);
      rd_chk(AECR_OFS_STATUS, 32'h000031C1);
      wr(AECR_OFS_STATUS, 32'hFFFF0101);
      rd_chk(AECR_OFS_STATUS, 32'h000030C0);
      wr(AECR_OFS_MASK, 32'hFFFFFFFF);
      rd_chk(AECR_OFS_MASK, 32'h000031C1);
      msgs = i_root.msg_count;
      foreach (pos[i]) pulse(pos[i]);
      rd_chk(AECR_OFS_STATUS, 32'h000031C1);
      chk(i_root.msg_count - msgs, 32'h00000000);
      $display("test events done");
      wr(AECR_OFS_CTRL, 32'hFFFFFF5F);
      rd_chk(AECR_OFS_CTRL, 32'h000001E0);
      chk({28'h0, gcap, gen, ccap, cen}, 32'h0000000F);
      write_lock <= 1'b0;
      wr(AECR_OFS_CTRL, 32'h00000000);
      rd_chk(AECR_OFS_CTRL, 32'h00000000);
      chk({28'h0, gcap, gen, ccap, cen}, 32'h00000000);
      first_err_load <= 1'b1;
      ptr <= 5'h1B;
      @(posedge clk);
      first_err_load <= 1'b0;
      wr(AECR_OFS_CTRL, 32'h00000140);
      rd_chk(AECR_OFS_CTRL, 32'h0000015B);
      $display("test control done");
      do_reset(1'b0);
      rd_chk(AECR_OFS_STATUS, 32'h000031C1);
      rd_chk(AECR_OFS_MASK, 32'h000031C1);
      rd_chk(AECR_OFS_CTRL, 32'h000001FB);
      do_reset(1'b1);
      rd_chk(AECR_OFS_STATUS, 32'h00000000);
      rd_chk(AECR_OFS_MASK, 32'h00002000);
      rd_chk(AECR_OFS_CTRL, 32'h000000A0);
      $display("test resets done");
      wr(AECR_OFS_IRQ_EN, 32'h00000040);
      pulse(0);
      repeat (2) @(posedge clk);
      chk({31'h0, irq}, 32'h00000000);
      pulse(6);
      repeat (2) @(posedge clk);
      chk({31'h0, irq}, 32'h00000001);
      rd_chk(AECR_OFS_IRQ_STAT, 32'h00000041);
      wr(AECR_OFS_IRQ_CLR, 32'h00000040);
      repeat (2) @(posedge clk);
      chk({31'h0, irq}, 32'h00000000);
      rd_chk(AECR_OFS_IRQ_STAT, 32'h00000001);
      rd_chk(AECR_OFS_IRQ_CLR, 32'h00000000);
      chk({31'h0, hresp}, 32'h00000000);
      $display("test interrupt done");
      print_verdict();
   end
endmodule : tb_top
`default_nettype wire
